/* core/tmr8_core.sv */
// Control-register slice of an 8-bit timer/counter with two compare
// channels, a prescaler decode, waveform generation and its registers.
// Assumes synchronous bus inputs on i_clock; pins need the direction bits.
// Functional notes
// - nonzero B mode drives B pin if direction set
// - non-PWM B modes: off, toggle, clear, set
// - fast PWM B: clear/set on match, reverse at TOP
// - phase-correct B: up-match and down-match opposite actions
// - compare equals TOP: ignore match, act at TOP, except channel A in phase-correct mode 1, which acts on up and down match
// - unused control bits always read zero
// - mode high bit from B, low bits from A
// - decode six modes, four and six reserved
// - compare buffering point and overflow flag point
// - force bits act only in non-PWM modes
// - force write is one-cycle strobe, forces match
// - forced match sets no flag, no clear
// - force bits always read as zero
// - clock select stops, passes or divides clock
// - counter write suppresses next timer-clock match
// - compare A equality raises flag, drives wave
// - non-PWM A modes: off, toggle, clear, set
// - PWM A mode one toggles only with high bit
// - phase-correct counts up, holds TOP, counts down
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tmr8_core (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire tmr8_pkg::tmr8_bus_t i_bus,
  output logic [7:0] o_rdata,
  output tmr8_pkg::tmr8_pins_t o_pins
);
  import tmr8_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [3:0] ctrl_b_reg;
  logic [7:0] count_reg, count_next;
  logic [7:0] cmp_a_reg, cmp_b_reg;
  logic [7:0] cmp_a_buf_reg, cmp_b_buf_reg;
  logic [2:0] flags_reg;
  logic [1:0] dir_reg;
  logic down_reg;
  logic block_reg;
  logic wave_a_reg, wave_b_reg;
  logic [TMR8_PRE_W-1:0] pre_reg;
  logic [7:0] rdata_reg;
  logic [2:0] wave_mode;
  logic [1:0] mode_a, mode_b;
  logic is_pwm, is_fast, is_pc, top_is_a;
  logic [7:0] top_val;
  logic tick;
  logic wr_a, wr_b, wr_cnt, wr_ca, wr_cb, wr_fl, wr_dir;
  logic force_a, force_b;
  logic match_a, match_b, at_top, ovf_evt;

  // Register port decode
  assign wr_a = i_bus.wr && (i_bus.addr == TMR8_ADDR_CTRL_A);
  assign wr_b = i_bus.wr && (i_bus.addr == TMR8_ADDR_CTRL_B);
  assign wr_cnt = i_bus.wr && (i_bus.addr == TMR8_ADDR_COUNT);
  assign wr_ca = i_bus.wr && (i_bus.addr == TMR8_ADDR_CMP_A);
  assign wr_cb = i_bus.wr && (i_bus.addr == TMR8_ADDR_CMP_B);
  assign wr_fl = i_bus.wr && (i_bus.addr == TMR8_ADDR_FLAGS);
  assign wr_dir = i_bus.wr && (i_bus.addr == TMR8_ADDR_PORT_DIR);

  // Mode decode; 4 and 6 fall back to normal mode, compare outputs included
  assign wave_mode = {ctrl_b_reg[TMR8_B_WAVE_HIGH],
                      ctrl_a_reg[TMR8_A_WAVE_HI:TMR8_A_WAVE_LO]};
  assign mode_a = ctrl_a_reg[TMR8_A_MODE_A_HI:TMR8_A_MODE_A_LO];
  assign mode_b = ctrl_a_reg[TMR8_A_MODE_B_HI:TMR8_A_MODE_B_LO];
  assign is_fast = (wave_mode == TMR8_WM_FAST_FF) ||
                   (wave_mode == TMR8_WM_FAST_CMPA);
  assign is_pc = (wave_mode == TMR8_WM_PC_FF) ||
                 (wave_mode == TMR8_WM_PC_CMPA);
  assign is_pwm = is_fast || is_pc;
  assign top_is_a = (wave_mode == TMR8_WM_CTC) ||
                    (wave_mode == TMR8_WM_PC_CMPA) ||
                    (wave_mode == TMR8_WM_FAST_CMPA);
  // PWM modes compare against the buffered copy
  assign top_val = top_is_a ? (is_pwm ? cmp_a_buf_reg : cmp_a_reg)
                            : TMR8_MAX;

  // Timer clock enable from the prescale counter
  always_comb begin
    case (ctrl_b_reg[TMR8_B_CLK_HI:TMR8_B_CLK_LO])
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_reg[2:0] == 3'h7);
      3'h3: tick = (pre_reg[4:0] == 5'h1F);
      3'h4: tick = (pre_reg[5:0] == 6'h3F);
      3'h5: tick = (pre_reg[6:0] == 7'h7F);
      3'h6: tick = (pre_reg[7:0] == 8'hFF);
      default: tick = (pre_reg == 10'h3FF);
    endcase
  end

  // Free-running prescaler; shared by all taps like a real prescaler
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  // Force strobes exist only for the write cycle and non-PWM modes
  assign force_a = wr_b && i_bus.wdata[TMR8_B_FORCE_A] &&
                   !is_pwm;
  assign force_b = wr_b && i_bus.wdata[TMR8_B_FORCE_B] &&
                   !is_pwm;

  // Compare matches on a timer tick, unless a counter write blocks them
  assign match_a = tick && !block_reg && !wr_cnt &&
                   (count_reg ==
                    (is_pwm ? cmp_a_buf_reg : cmp_a_reg));
  assign match_b = tick && !block_reg && !wr_cnt &&
                   (count_reg == (is_pwm ? cmp_b_buf_reg : cmp_b_reg));
  assign at_top = tick && (count_reg == top_val);

  // Overflow point per mode
  always_comb begin
    if (is_pc) begin
      ovf_evt = tick && (count_reg == TMR8_BOTTOM) && down_reg;
    end else if (wave_mode == TMR8_WM_FAST_CMPA) begin
      ovf_evt = at_top;
    end else begin
      ovf_evt = tick && (count_reg == TMR8_MAX);
    end
  end

  // Counter sequencing
  always_comb begin
    count_next = count_reg;
    if (tick) begin
      if (is_pc) begin
        if (down_reg) begin
          count_next = count_reg - 8'h01;
        end else if (count_reg != top_val) begin
          count_next = count_reg + 8'h01;
        end
      end else if (wave_mode == TMR8_WM_CTC && match_a) begin
        count_next = TMR8_BOTTOM;
      end else if (count_reg == top_val) begin
        count_next = TMR8_BOTTOM;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  // Counter register; a software write wins over counting
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      count_reg <= TMR8_DATA_RESET;
    end else if (wr_cnt) begin
      count_reg <= i_bus.wdata;
    end else begin
      count_reg <= count_next;
    end
  end

  // Direction: turn at TOP after holding it one tick, and at BOTTOM
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      down_reg <= 1'b0;
    end else if (!is_pc) begin
      down_reg <= 1'b0;
    end else if (tick && !down_reg && count_reg == top_val) begin
      down_reg <= 1'b1;
    end else if (tick && down_reg && count_next == TMR8_BOTTOM) begin
      down_reg <= 1'b0;
    end
  end

  // Match blocking lasts until the next timer tick after a count write
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      block_reg <= 1'b0;
    end else if (wr_cnt) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // Control and data registers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_a_reg <= TMR8_CTRL_RESET;
      ctrl_b_reg <= TMR8_CTRL_RESET[3:0];
      cmp_a_reg <= TMR8_DATA_RESET;
      cmp_b_reg <= TMR8_DATA_RESET;
      dir_reg <= 2'h0;
    end else begin
      if (wr_a) begin
        ctrl_a_reg <= i_bus.wdata & TMR8_CTRL_A_RMASK;
      end
      if (wr_b) begin
        ctrl_b_reg <= i_bus.wdata[3:0];
      end
      if (wr_ca) begin
        cmp_a_reg <= i_bus.wdata;
      end
      if (wr_cb) begin
        cmp_b_reg <= i_bus.wdata;
      end
      if (wr_dir) begin
        dir_reg <= i_bus.wdata[1:0];
      end
    end
  end

  // Active compare copies: immediate outside PWM, latched at TOP in PWM
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cmp_a_buf_reg <= TMR8_DATA_RESET;
      cmp_b_buf_reg <= TMR8_DATA_RESET;
    end else if (!is_pwm || at_top) begin
      cmp_a_buf_reg <= cmp_a_reg;
      cmp_b_buf_reg <= cmp_b_reg;
    end
  end

  // Sticky flags; write one clears, a same-cycle event wins
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      flags_reg <= 3'h0;
    end else begin
      flags_reg <= (flags_reg & ~(wr_fl ? i_bus.wdata[2:0] : 3'h0)) |
                   {match_b, match_a, ovf_evt};
    end
  end

  // Channel A waveform
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wave_a_reg <= 1'b0;
    end else if (!is_pwm) begin
      if (match_a || force_a) begin
        case (mode_a)
          TMR8_OM_TOGGLE: wave_a_reg <= !wave_a_reg;
          TMR8_OM_CLEAR: wave_a_reg <= 1'b0;
          TMR8_OM_SET: wave_a_reg <= 1'b1;
          default: wave_a_reg <= wave_a_reg;
        endcase
      end
    end else if (mode_a == TMR8_OM_TOGGLE) begin
      if (match_a && wave_mode[2]) begin
        wave_a_reg <= !wave_a_reg;
      end
    end else if (mode_a[1]) begin
      if (top_is_a && at_top) begin
        // Compare equals TOP: match ignored, TOP action only
        // Fast: the TOP action; dual slope: the down-match level
        wave_a_reg <= !mode_a[0];
      end else if (is_fast && at_top) begin
        wave_a_reg <= !mode_a[0];
      end else if (match_a) begin
        wave_a_reg <= down_reg ? !mode_a[0] : mode_a[0];
      end
    end
  end

  // Channel B waveform
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wave_b_reg <= 1'b0;
    end else if (!is_pwm) begin
      if (match_b || force_b) begin
        case (mode_b)
          TMR8_OM_TOGGLE: wave_b_reg <= !wave_b_reg;
          TMR8_OM_CLEAR: wave_b_reg <= 1'b0;
          TMR8_OM_SET: wave_b_reg <= 1'b1;
          default: wave_b_reg <= wave_b_reg;
        endcase
      end
    end else if (mode_b[1]) begin
      if (cmp_b_buf_reg == top_val && at_top) begin
        wave_b_reg <= !mode_b[0];
      end else if (is_fast && at_top) begin
        wave_b_reg <= !mode_b[0];
      end else if (is_fast && match_b) begin
        wave_b_reg <= mode_b[0];
      end else if (match_b) begin
        wave_b_reg <= down_reg ? !mode_b[0] : mode_b[0];
      end
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        TMR8_ADDR_CTRL_A: rdata_reg <= ctrl_a_reg & TMR8_CTRL_A_RMASK;
        TMR8_ADDR_CTRL_B: rdata_reg <= {4'h0, ctrl_b_reg};
        TMR8_ADDR_COUNT: rdata_reg <= count_reg;
        TMR8_ADDR_CMP_A: rdata_reg <= cmp_a_reg;
        TMR8_ADDR_CMP_B: rdata_reg <= cmp_b_reg;
        TMR8_ADDR_FLAGS: rdata_reg <= {5'h00, flags_reg};
        TMR8_ADDR_PORT_DIR: rdata_reg <= {6'h00, dir_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_reg;

  // Pin drive: fast PWM/PC reserved code 1 on A leaves pin on port unless the mode high bit is set
  assign o_pins.wave_a = wave_a_reg;
  assign o_pins.wave_b = wave_b_reg;
  assign o_pins.en_a = dir_reg[0] && (mode_a != TMR8_OM_OFF) &&
                       !(is_pwm && mode_a == TMR8_OM_TOGGLE &&
                         !wave_mode[2]);
  assign o_pins.en_b = dir_reg[1] && (mode_b != TMR8_OM_OFF);

endmodule
`default_nettype wire

/* include/tmr8_pkg.sv */
// Package for the 8-bit timer control-register slice: register map,
// field positions, reset values, waveform modes and prescale divider width.
// Assumes a plain address/strobe register port and one 10 MHz clock.
package tmr8_pkg;

  // Register indices on the plain register port (4-bit address)
  localparam logic [3:0] TMR8_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] TMR8_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] TMR8_ADDR_COUNT = 4'h2;
  localparam logic [3:0] TMR8_ADDR_CMP_A = 4'h3;
  localparam logic [3:0] TMR8_ADDR_CMP_B = 4'h4;
  localparam logic [3:0] TMR8_ADDR_FLAGS = 4'h5;
  localparam logic [3:0] TMR8_ADDR_PORT_DIR = 4'h6;

  // Field positions in control A
  localparam int TMR8_A_MODE_A_HI = 7;
  localparam int TMR8_A_MODE_A_LO = 6;
  localparam int TMR8_A_MODE_B_HI = 5;
  localparam int TMR8_A_MODE_B_LO = 4;
  localparam int TMR8_A_WAVE_HI = 1;
  localparam int TMR8_A_WAVE_LO = 0;
  localparam logic [7:0] TMR8_CTRL_A_RMASK = 8'hF3;

  // Field positions in control B
  localparam int TMR8_B_FORCE_A = 7;
  localparam int TMR8_B_FORCE_B = 6;
  localparam int TMR8_B_WAVE_HIGH = 3;
  localparam int TMR8_B_CLK_HI = 2;
  localparam int TMR8_B_CLK_LO = 0;

  // Flag bits: overflow, match A, match B
  localparam int TMR8_FLAG_OVF = 0;
  localparam int TMR8_FLAG_MATCH_A = 1;
  localparam int TMR8_FLAG_MATCH_B = 2;

  // Reset values
  localparam logic [7:0] TMR8_CTRL_RESET = 8'h00;
  localparam logic [7:0] TMR8_DATA_RESET = 8'h00;

  // Counter limits
  localparam logic [7:0] TMR8_MAX = 8'hFF;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;

  // Waveform mode codes
  localparam logic [2:0] TMR8_WM_NORMAL = 3'h0;
  localparam logic [2:0] TMR8_WM_PC_FF = 3'h1;
  localparam logic [2:0] TMR8_WM_CTC = 3'h2;
  localparam logic [2:0] TMR8_WM_FAST_FF = 3'h3;
  localparam logic [2:0] TMR8_WM_PC_CMPA = 3'h5;
  localparam logic [2:0] TMR8_WM_FAST_CMPA = 3'h7;

  // Output-mode codes
  localparam logic [1:0] TMR8_OM_OFF = 2'h0;
  localparam logic [1:0] TMR8_OM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_OM_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_OM_SET = 2'h3;

  // Prescale divider width: longest division is 1024
  localparam int TMR8_PRE_W = 10;

  // Register access bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmr8_bus_t;

  // Compare outputs with their pin drive enables
  typedef struct packed {
    logic wave_a;
    logic en_a;
    logic wave_b;
    logic en_b;
  } tmr8_pins_t;

endpackage

/* tb/tmr8_core_asserts.sv */
// Checker for the timer control slice: port-level relations only.
// Assumes it is bound to tmr8_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tmr8_core_asserts (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire tmr8_pkg::tmr8_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire tmr8_pkg::tmr8_pins_t o_pins
);
  import tmr8_pkg::*;
  logic [7:0] sh_a_reg;
  logic [3:0] sh_b_reg;
  logic [1:0] sh_dir_reg;
  logic fb;

  // Shadow of the written control state, so enables can be predicted
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      sh_a_reg <= 8'h00;
      sh_b_reg <= 4'h0;
      sh_dir_reg <= 2'h0;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        TMR8_ADDR_CTRL_A: sh_a_reg <= i_bus.wdata;
        TMR8_ADDR_CTRL_B: sh_b_reg <= i_bus.wdata[3:0];
        TMR8_ADDR_PORT_DIR: sh_dir_reg <= i_bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  // Write to control B, seen at the sampling edge
  assign fb = i_bus.wr && i_bus.addr == TMR8_ADDR_CTRL_B;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_rdata_hold;
    !i_bus.rd |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
  property p_ctrl_a_read;
    i_bus.rd && i_bus.addr == TMR8_ADDR_CTRL_A
      |=> o_rdata == (sh_a_reg & TMR8_CTRL_A_RMASK);
  endproperty
  a_ctrl_a_read: assert property (p_ctrl_a_read)
    else $error("control A read back wrong");
  property p_ctrl_b_read;
    i_bus.rd && i_bus.addr == TMR8_ADDR_CTRL_B |=> o_rdata == {4'h0, sh_b_reg};
  endproperty
  a_ctrl_b_read: assert property (p_ctrl_b_read)
    else $error("control B read back wrong");
  property p_en_b;
    o_pins.en_b == (sh_dir_reg[1] && sh_a_reg[5:4] != TMR8_OM_OFF);
  endproperty
  a_en_b: assert property (p_en_b)
    else $error("channel B pin enable wrong");
  property p_en_a;
    o_pins.en_a == (sh_dir_reg[0] && sh_a_reg[7:6] != TMR8_OM_OFF &&
      !(sh_a_reg[7:6] == TMR8_OM_TOGGLE && sh_a_reg[0] && !sh_b_reg[3]));
  endproperty
  a_en_a: assert property (p_en_a)
    else $error("channel A pin enable wrong");
  property p_force_a_set;
    fb && i_bus.wdata[TMR8_B_FORCE_A] && !sh_a_reg[0] &&
      sh_a_reg[7:6] == TMR8_OM_SET |-> ##[1:3] o_pins.wave_a;
  endproperty
  a_force_a_set: assert property (p_force_a_set)
    else $error("forced set on channel A missing");
  property p_force_b_clr;
    fb && i_bus.wdata[TMR8_B_FORCE_B] && !sh_a_reg[0] &&
      sh_a_reg[5:4] == TMR8_OM_CLEAR |-> ##[1:3] !o_pins.wave_b;
  endproperty
  a_force_b_clr: assert property (p_force_b_clr)
    else $error("forced clear on channel B missing");
  property p_force_pwm;
    fb && i_bus.wdata[TMR8_B_FORCE_A] && sh_a_reg[0] &&
      i_bus.wdata[2:0] == 3'h0 && sh_b_reg[2:0] == 3'h0
      |=> $stable(o_pins.wave_a) [*3];
  endproperty
  a_force_pwm: assert property (p_force_pwm)
    else $error("force acted in a PWM mode");
endmodule
bind tmr8_core tmr8_core_asserts u_tmr8_core_asserts (.i_clock(i_clock),
  .i_nrst(i_nrst), .i_bus(i_bus), .o_rdata(o_rdata), .o_pins(o_pins));
`default_nettype wire

/* tb/tmr8_core_tb_top.sv */
// Self-checking bench for the timer control slice: register port tasks
// and directed sequences. Assumes the package register map, one clock.
`timescale 1ns/10ps
`default_nettype none
module tmr8_core_tb_top;
  import tmr8_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  tmr8_bus_t bus = '0;
  logic [7:0] rdata, v, r0;
  tmr8_pins_t pins;
  int n_errors = 0;
  int tests_run = 0;
  int i;
  int divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] om[4] = '{2'h1, 2'h1, 2'h3, 2'h2};

  tmr8_core u_tmr8_core (.i_clock(i_clock), .i_nrst(i_nrst), .i_bus(bus),
    .o_rdata(rdata), .o_pins(pins));

  // 10 MHz clock
  always #50 i_clock = ~i_clock;

  task automatic chk(input string n, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Strobes last one cycle; the next call waits an edge, so no clash
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask
  // Runs from 0x0E for the same tick span in any waveform mode
  task automatic run(input logic [2:0] m, output logic [7:0] d);
    wr(TMR8_ADDR_CTRL_A, {6'h00, m[1:0]});
    wr(TMR8_ADDR_COUNT, 8'h0E);
    wr(TMR8_ADDR_CTRL_B, {4'h0, m[2], 3'h1});
    repeat (18) @(posedge i_clock);
    wr(TMR8_ADDR_CTRL_B, {4'h0, m[2], 3'h0});
    rd(TMR8_ADDR_COUNT, d);
  endtask
  // Expected count after t ticks from 0x0E, compare A (0x10) as TOP
  function automatic logic [7:0] model(input int m, input int t);
    logic [7:0] c;
    logic up;
    c = 8'h0E;
    up = 1'b1;
    repeat (t) begin
      if (m == 5) begin
        // TOP is held for one tick before the count turns down
        if (up && c == 8'h10) begin
          up = 1'b0;
        end else begin
          if (!up && c == 8'h00) up = 1'b1;
          c = up ? c + 8'h01 : c - 8'h01;
        end
      end else if ((m == 2 || m == 7) && c == 8'h10) c = 8'h00;
      else c = c + 8'h01;
    end
    return c;
  endfunction
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 6400 cycles of the sequence
  initial begin
    repeat (30000) @(posedge i_clock);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    for (i = 0; i < 4; i++) rchk("reset", i[3:0], 8'h00);
    wr(TMR8_ADDR_CTRL_A, 8'hFF);
    rchk("ctrl_a", TMR8_ADDR_CTRL_A, 8'hF3);
    wr(TMR8_ADDR_CTRL_B, 8'hF0);
    rchk("ctrl_b", TMR8_ADDR_CTRL_B, 8'h00);
    rchk("unmapped", 4'hF, 8'h00);
    wr(TMR8_ADDR_CMP_A, 8'h10);
    wr(TMR8_ADDR_COUNT, 8'h5A);
    rchk("count", TMR8_ADDR_COUNT, 8'h5A);
    // Mode sweep; the normal-mode result fixes the tick span
    run(TMR8_WM_NORMAL, r0);
    chk("span", r0, 8'h22);
    for (i = 1; i < 8; i++) begin
      run(i[2:0], v);
      chk("mode", v, model(i, int'(r0 - 8'h0E)));
    end
    // Prescale taps: four ticks in four divided periods
    wr(TMR8_ADDR_CTRL_A, 8'h00);
    for (i = 0; i < 7; i++) begin
      wr(TMR8_ADDR_CTRL_B, {5'h00, 3'(i + 1)});
      rd(TMR8_ADDR_COUNT, r0);
      repeat (divs[i] * 4 - 2) @(posedge i_clock);
      rd(TMR8_ADDR_COUNT, v);
      chk("prescale", v - r0, 8'h04);
    end
    wr(TMR8_ADDR_CTRL_B, 8'h00);
    wr(TMR8_ADDR_CMP_A, 8'h80);
    wr(TMR8_ADDR_CMP_B, 8'h80);
    wr(TMR8_ADDR_COUNT, 8'h33);
    wr(TMR8_ADDR_PORT_DIR, 8'h03);
    wr(TMR8_ADDR_FLAGS, 8'h07);
    // Forced matches in clear-on-match: toggle twice, set, clear
    for (i = 0; i < 4; i++) begin
      wr(TMR8_ADDR_CTRL_A, {om[i], om[i], 4'h2});
      wr(TMR8_ADDR_CTRL_B, 8'hC0);
      repeat (3) @(posedge i_clock);
      #1;
      chk("wave_a", {7'h00, pins.wave_a}, {7'h00, ~i[0]});
      chk("wave_b", {7'h00, pins.wave_b}, {7'h00, ~i[0]});
      chk("pin_en", {6'h00, pins.en_a, pins.en_b}, 8'h03);
    end
    rchk("flags", TMR8_ADDR_FLAGS, 8'h00);
    rchk("count", TMR8_ADDR_COUNT, 8'h33);
    // Toggle in fast PWM needs the high mode bit; force is ignored
    wr(TMR8_ADDR_CTRL_A, 8'h43);
    #1;
    chk("en_a", {7'h00, pins.en_a}, 8'h00);
    wr(TMR8_ADDR_CTRL_B, 8'h80);
    repeat (3) @(posedge i_clock);
    #1;
    chk("wave_a", {7'h00, pins.wave_a}, 8'h00);
    wr(TMR8_ADDR_CTRL_B, 8'h08);
    #1;
    chk("en_a", {7'h00, pins.en_a}, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
